// ### verilog/pim_pkg.sv
// Constants and carrier types for the port pin block.
// Assumes an APB slave with 32-bit data, one register per word.
package pim_pkg;

	localparam int NPIN = 8;
	localparam int AW   = 10;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_AD_DATA  = 8'h30;
	localparam logic [7:0] IDX_AD_IN    = 8'h31;
	localparam logic [7:0] IDX_AD_DIR   = 8'h32;
	localparam logic [7:0] IDX_AD_RDR   = 8'h33;
	localparam logic [7:0] IDX_AD_PE    = 8'h34;
	localparam logic [7:0] IDX_AD_PS    = 8'h35;
	localparam logic [7:0] IDX_TM_DATA  = 8'h38;
	localparam logic [7:0] IDX_TM_DIR   = 8'h39;
	localparam logic [7:0] IDX_REROUTE  = 8'h3A;
	localparam logic [7:0] IDX_SER_PE   = 8'h3B;
	localparam logic [7:0] IDX_SER_WOR  = 8'h3C;
	localparam logic [7:0] IDX_EP_DATA  = 8'h3D;
	localparam logic [7:0] IDX_EP_DIR   = 8'h3E;
	localparam logic [7:0] IDX_EP_PE    = 8'h3F;
	localparam logic [7:0] IDX_EP_POL   = 8'h40;
	localparam logic [7:0] IDX_EP_IE    = 8'h41;
	localparam logic [7:0] IDX_EP_IF    = 8'h42;

	localparam logic [7:0]  RST_ZERO   = 8'h00;
	localparam logic [7:0]  RST_SER_PE = 8'hFF;
	localparam logic [23:0] RD_PAD     = 24'h000000;
	localparam logic [1:0]  ALIGN_OK   = 2'h0;

	// Glitch filter sample threshold
	localparam logic [2:0] FILT_SAMPLES = 3'h4;
	localparam logic [2:0] CNT_ONE      = 3'h1;

	typedef struct packed {
		logic [7:0] data, dir, rdr, pe, ps, s1, s2;
	} pim_ad_t;

	typedef struct packed {
		logic [7:0]      data, dir, pe, pol, ie, flag;
		logic [7:0]      s1, s2, prev, armed;
		logic [7:0][2:0] cnt;
	} pim_ep_t;

	typedef struct packed {
		pim_ad_t     ad;
		logic [7:0]  tm_data, tm_dir, reroute, ser_pe, ser_wor;
		pim_ep_t     ep;
		logic [31:0] rdata;
	} pim_state_t;

	typedef struct packed {
		logic [7:0] own, oe, out;
	} pim_periph_t;

	typedef struct packed {
		logic [7:0] out, oe, pull_en, pull_up;
	} pim_pad_t;

endpackage

// ### verilog/pim_port.sv
// Port pin logic: converter-shared port, timer port, serial pulls and
// an edge-interrupt port with glitch filters, all behind an APB slave.
// Assumes pin inputs synchronous to pclk and one clock throughout.
`timescale 1ns/1ps

module pim_port (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [pim_pkg::AW-1:0] paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic [7:0]           ad_pin_in,
	input  wire logic [7:0]           ad_conv_en,
	input  wire pim_pkg::pim_periph_t ad_periph,
	output pim_pkg::pim_pad_t         ad_pad,
	output logic      [7:0]           ad_drive_reduced,
	input  wire pim_pkg::pim_periph_t tm_periph,
	input  wire logic [7:0]           pwm_out,
	output pim_pkg::pim_pad_t         tm_pad,
	input  wire logic [7:0]           ser_periph_oe,
	output logic      [7:0]           ser_pull_up_en,
	input  wire logic [7:0]           ep_pin_in,
	output pim_pkg::pim_pad_t         ep_pad,
	input  wire logic                 stop_mode,
	output logic                      edge_irq_req,
	output logic                      wakeup_req,
	output logic                      rc_osc_run
);
	import pim_pkg::*;

	pim_state_t r_reg;
	pim_state_t r_next;
	logic [7:0] idx;
	logic       hit;
	logic [7:0] rd;
	logic [7:0] edge_hit;
	logic [7:0] wclr;
	logic       wr_acc;

	assign idx    = paddr[AW-1:2];
	assign wr_acc = psel & penable & pwrite & hit;
	assign wclr   = (wr_acc && idx == IDX_EP_IF) ? pwdata[7:0] : RST_ZERO;

	// --------------------------------------------------------------
	// Read decode
	// --------------------------------------------------------------
	always_comb begin
		hit = 1'b1;
		case (idx)
			IDX_AD_DATA: rd = (r_reg.ad.dir & r_reg.ad.data)
				| (~r_reg.ad.dir & r_reg.ad.s2);
			IDX_AD_IN:   rd = r_reg.ad.s2;
			IDX_AD_DIR:  rd = r_reg.ad.dir;
			IDX_AD_RDR:  rd = r_reg.ad.rdr;
			IDX_AD_PE:   rd = r_reg.ad.pe;
			IDX_AD_PS:   rd = r_reg.ad.ps;
			IDX_TM_DATA: rd = r_reg.tm_data;
			IDX_TM_DIR:  rd = r_reg.tm_dir;
			IDX_REROUTE: rd = r_reg.reroute;
			IDX_SER_PE:  rd = r_reg.ser_pe;
			IDX_SER_WOR: rd = r_reg.ser_wor;
			IDX_EP_DATA: rd = (r_reg.ep.dir & r_reg.ep.data)
				| (~r_reg.ep.dir & r_reg.ep.s2);
			IDX_EP_DIR:  rd = r_reg.ep.dir;
			IDX_EP_PE:   rd = r_reg.ep.pe;
			IDX_EP_POL:  rd = r_reg.ep.pol;
			IDX_EP_IE:   rd = r_reg.ep.ie;
			IDX_EP_IF:   rd = r_reg.ep.flag;
			default: begin
				rd  = RST_ZERO;
				hit = 1'b0;
			end
		endcase
		if (paddr[1:0] != ALIGN_OK) begin
			rd  = RST_ZERO;
			hit = 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb begin
		r_next = r_reg;
		edge_hit = RST_ZERO;
		// Two stages, hence the two-cycle stale read after a change
		r_next.ad.s1 = ad_pin_in;
		r_next.ad.s2 = r_reg.ad.s1;
		r_next.ep.s1 = ep_pin_in;
		r_next.ep.s2 = r_reg.ep.s1;
		r_next.ep.prev = r_reg.ep.s2;
		// Filters always on pclk; the stop-mode RC is outside this block
		for (int i = 0; i < NPIN; i++) begin
			if (r_reg.ep.s2[i] != r_reg.ep.prev[i]) begin
				r_next.ep.cnt[i] = CNT_ONE;
			end else if (r_reg.ep.cnt[i] != FILT_SAMPLES) begin
				r_next.ep.cnt[i] = r_reg.ep.cnt[i] + CNT_ONE;
			end
			// Counter level is prev; active level equals polarity
			if (r_reg.ep.cnt[i] == FILT_SAMPLES) begin
				if (r_reg.ep.prev[i] != r_reg.ep.pol[i]) begin
					r_next.ep.armed[i] = 1'b1;
				end else if (r_reg.ep.armed[i]) begin
					edge_hit[i] = 1'b1;
					r_next.ep.armed[i] = 1'b0;
				end
			end
		end
		// Set wins over a clear in the same cycle
		r_next.ep.flag = (r_reg.ep.flag & ~wclr) | edge_hit;
		if (wr_acc) begin
			case (idx)
				IDX_AD_DATA: r_next.ad.data = pwdata[7:0];
				IDX_AD_DIR:  r_next.ad.dir = pwdata[7:0];
				IDX_AD_RDR:  r_next.ad.rdr = pwdata[7:0];
				IDX_AD_PE:   r_next.ad.pe = pwdata[7:0];
				IDX_AD_PS:   r_next.ad.ps = pwdata[7:0];
				IDX_TM_DATA: r_next.tm_data = pwdata[7:0];
				IDX_TM_DIR:  r_next.tm_dir = pwdata[7:0];
				IDX_REROUTE: r_next.reroute = pwdata[7:0];
				IDX_SER_PE:  r_next.ser_pe = pwdata[7:0];
				IDX_SER_WOR: r_next.ser_wor = pwdata[7:0];
				IDX_EP_DATA: r_next.ep.data = pwdata[7:0];
				IDX_EP_DIR:  r_next.ep.dir = pwdata[7:0];
				IDX_EP_PE:   r_next.ep.pe = pwdata[7:0];
				IDX_EP_POL:  r_next.ep.pol = pwdata[7:0];
				IDX_EP_IE:   r_next.ep.ie = pwdata[7:0];
				default: begin
				end
			endcase
		end
		// Read data caught in setup so it stands from a flop in access
		if (psel && !penable && !pwrite) begin
			r_next.rdata = {RD_PAD, rd};
		end
	end

	// --------------------------------------------------------------
	// State register
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// All zero but ser_pe all ones: every port an input, serial pulls on, others off
			r_reg        <= '0;
			r_reg.ser_pe <= RST_SER_PE;
		end else begin
			r_reg <= r_next;
		end
	end

	// --------------------------------------------------------------
	// Bus answer
	// --------------------------------------------------------------
	assign prdata  = r_reg.rdata;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;

	// --------------------------------------------------------------
	// Pins
	// --------------------------------------------------------------
	always_comb begin
		ad_pad.oe = (ad_periph.own & ad_periph.oe)
			| (~ad_periph.own & r_reg.ad.dir);
		ad_pad.out = (ad_periph.own & ad_periph.out)
			| (~ad_periph.own & r_reg.ad.data);
		// Converter channel wins so the pull never loads the analog input
		ad_pad.pull_en = r_reg.ad.pe & ~ad_pad.oe
			& ~ad_conv_en;
		ad_pad.pull_up = ~r_reg.ad.ps;
		ad_drive_reduced = r_reg.ad.rdr & ad_pad.oe;
		tm_pad.oe = r_reg.reroute | (tm_periph.own & tm_periph.oe)
			| (~tm_periph.own & r_reg.tm_dir);
		tm_pad.out = (r_reg.reroute & pwm_out)
			| (~r_reg.reroute & tm_periph.own & tm_periph.out)
			| (~r_reg.reroute & ~tm_periph.own & r_reg.tm_data);
		tm_pad.pull_en = RST_ZERO;
		tm_pad.pull_up = RST_ZERO;
		ser_pull_up_en = r_reg.ser_pe
			& (~ser_periph_oe | r_reg.ser_wor);
		ep_pad.oe = r_reg.ep.dir;
		ep_pad.out = r_reg.ep.data;
		ep_pad.pull_en = r_reg.ep.pe & ~r_reg.ep.dir;
		ep_pad.pull_up = ~r_reg.ep.pol;
	end

	// --------------------------------------------------------------
	// Edge request and stop-mode oscillator demand
	// --------------------------------------------------------------
	assign edge_irq_req = |(r_reg.ep.flag & r_reg.ep.ie);
	assign wakeup_req   = edge_irq_req;
	always_comb begin
		rc_osc_run = 1'b0;
		for (int i = 0; i < NPIN; i++) begin
			if (stop_mode && r_reg.ep.cnt[i] <= FILT_SAMPLES
				&& r_reg.ep.ie[i] && !r_reg.ep.flag[i]) begin
				rc_osc_run = 1'b1;
			end
		end
	end

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_in_latency;
		1'b1 |-> ##2 r_reg.ad.s2 == $past(ad_pin_in, 2);
	endproperty
	a_in_latency: assert property (p_in_latency)
		else $error("input sample latency wrong");

	property p_in_read;
		psel && !penable && !pwrite && idx == IDX_AD_IN
			|=> prdata[7:0] == $past(r_reg.ad.s2);
	endproperty
	a_in_read: assert property (p_in_read)
		else $error("input register read wrong");

	property p_data_wr;
		wr_acc && idx == IDX_AD_DATA
			|=> r_reg.ad.data == $past(pwdata[7:0]);
	endproperty
	a_data_wr: assert property (p_data_wr)
		else $error("data write not stored");

	property p_set_wins;
		edge_hit != RST_ZERO
			|=> (r_reg.ep.flag & $past(edge_hit)) == $past(edge_hit);
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("edge flag lost");

	property p_zero_wr;
		wr_acc && idx == IDX_EP_IF && pwdata[7:0] == RST_ZERO
			&& edge_hit == RST_ZERO |=> $stable(r_reg.ep.flag);
	endproperty
	a_zero_wr: assert property (p_zero_wr)
		else $error("zero write changed a flag");

	property p_irq;
		(edge_hit & r_reg.ep.ie) != RST_ZERO |=> edge_irq_req;
	endproperty
	a_irq: assert property (p_irq)
		else $error("no request after enabled edge");

	property p_filter;
		edge_hit[0] |-> $past(r_reg.ep.prev[0], 1) == r_reg.ep.prev[0]
			&& $past(r_reg.ep.prev[0], 2) == r_reg.ep.prev[0]
			&& $past(r_reg.ep.prev[0], 3) == r_reg.ep.prev[0];
	endproperty
	a_filter: assert property (p_filter)
		else $error("edge taken from short pulse");

	property p_owner;
		ad_periph.own[0] |-> ad_pad.oe[0] == ad_periph.oe[0];
	endproperty
	a_owner: assert property (p_owner)
		else $error("peripheral direction not honoured");

	property p_conv_pull;
		(ad_conv_en & ad_pad.pull_en) == RST_ZERO;
	endproperty
	a_conv_pull: assert property (p_conv_pull)
		else $error("pull on with converter channel");

	property p_reroute;
		r_reg.reroute[0] |-> tm_pad.out[0] == pwm_out[0] && tm_pad.oe[0];
	endproperty
	a_reroute: assert property (p_reroute)
		else $error("rerouted channel not driven");

	property p_pushpull;
		ser_periph_oe[0] && !r_reg.ser_wor[0] |-> !ser_pull_up_en[0];
	endproperty
	a_pushpull: assert property (p_pushpull)
		else $error("pull on push-pull output");

	property p_dir_wr;
		wr_acc && idx == IDX_AD_DIR |=> (ad_pad.oe & ~ad_periph.own)
			== ($past(pwdata[7:0]) & ~ad_periph.own);
	endproperty
	a_dir_wr: assert property (p_dir_wr)
		else $error("direction write not applied");

	property p_drive_reduce;
		wr_acc && idx == IDX_AD_RDR
			|=> ad_drive_reduced == ($past(pwdata[7:0]) & ad_pad.oe);
	endproperty
	a_drive_reduce: assert property (p_drive_reduce)
		else $error("reduced drive wrong");

	property p_pull_out;
		(ad_pad.pull_en & ad_pad.oe) == RST_ZERO
			&& (ep_pad.pull_en & ep_pad.oe) == RST_ZERO;
	endproperty
	a_pull_out: assert property (p_pull_out)
		else $error("pull on an output pin");

	property p_pull_sel;
		wr_acc && idx == IDX_AD_PS |=> ad_pad.pull_up == ~$past(pwdata[7:0]);
	endproperty
	a_pull_sel: assert property (p_pull_sel)
		else $error("converter pull select wrong");

	property p_pol_pull;
		wr_acc && idx == IDX_EP_POL |=> ep_pad.pull_up == ~$past(pwdata[7:0]);
	endproperty
	a_pol_pull: assert property (p_pol_pull)
		else $error("polarity pull select wrong");

	property p_rc_idle;
		!stop_mode |-> !rc_osc_run;
	endproperty
	a_rc_idle: assert property (p_rc_idle)
		else $error("local oscillator runs outside stop");

endmodule

// ### testbench/pim_board.sv
// Board-side model of the port pins: turns the converter and edge-port pads into pin levels.
// Assumes pad outputs of the port block and free external sources.
`timescale 1ns/1ps

module pim_board (
	input  wire pim_pkg::pim_pad_t ad_pad,
	input  wire logic [7:0]        ad_ext,
	output logic      [7:0]        ad_pin,
	input  wire pim_pkg::pim_pad_t ep_pad,
	input  wire logic [7:0]        ep_ext,
	output logic      [7:0]        ep_pin
);
	import pim_pkg::*;

	// Pad drive wins, then an enabled pull, then the external source
	function automatic logic [7:0] level(input pim_pad_t p,
		input logic [7:0] x);
		return (p.oe & p.out) | (~p.oe & p.pull_en & p.pull_up) |
			(~p.oe & ~p.pull_en & x);
	endfunction

	assign ad_pin = level(ad_pad, ad_ext);
	assign ep_pin = level(ep_pad, ep_ext);
endmodule

// ### testbench/port_pin_io_with_edge_wakeup_tb.sv
// Self-checking bench for the port pin block, APB master and pin stimulus.
// Assumes pim_port and the board model pim_board.
`timescale 1ns/1ps

module port_pin_io_with_edge_wakeup_tb;
	import pim_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, stop_mode = 1'b0, pready, pslverr;
	logic edge_irq_req, wakeup_req, rc_osc_run;
	logic [AW-1:0] paddr = '0;
	logic [31:0] pwdata = 32'h0, prdata, seed = 32'h2FF2, r;
	logic [7:0] ad_pin_in, ep_pin_in, ad_drive_reduced, ser_pull_up_en;
	logic [7:0] ad_conv_en = 8'h00, pwm_out = 8'h00, ser_periph_oe = 8'h00;
	logic [7:0] ad_ext = 8'h00, ep_ext = 8'h00, idle;
	logic [7:0] dir, dat, rdr, pe, ps, oe, out, pe_eff, pin;
	pim_periph_t ad_periph = '0, tm_periph = '0;
	pim_pad_t ad_pad, tm_pad, ep_pad;
	int errors = 0, total_checks = 0;
	logic [32:0] exp_q[$];

	always #4 pclk = ~pclk;

	pim_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ad_pin_in(ad_pin_in), .ad_conv_en(ad_conv_en),
		.ad_periph(ad_periph), .ad_pad(ad_pad),
		.ad_drive_reduced(ad_drive_reduced), .tm_periph(tm_periph),
		.pwm_out(pwm_out), .tm_pad(tm_pad), .ser_periph_oe(ser_periph_oe),
		.ser_pull_up_en(ser_pull_up_en), .ep_pin_in(ep_pin_in),
		.ep_pad(ep_pad), .stop_mode(stop_mode), .edge_irq_req(edge_irq_req),
		.wakeup_req(wakeup_req), .rc_osc_run(rc_osc_run));

	pim_board u_board (.ad_pad(ad_pad), .ad_ext(ad_ext), .ad_pin(ad_pin_in),
		.ep_pad(ep_pad), .ep_ext(ep_ext), .ep_pin(ep_pin_in));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction

	task check(input logic [32:0] seen, input logic [32:0] expv);
		total_checks++;
		if (seen !== expv) begin
			errors++;
			$display("[ERR] %0t saw %h expected %h", $time, seen, expv);
		end
	endtask

	task ck(input logic [7:0] seen, input logic [7:0] expv);
		check({25'h0, seen}, {25'h0, expv});
	endtask

	task stop_test();
		if (exp_q.size() != 0)
			errors++;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task apb(input logic [7:0] idx, input logic wr, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			stop_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] v;
		v = rnd();
		apb(idx, 1'b1, {v[31:8], d});
	endtask

	task rd(input logic [7:0] idx, input logic err, input logic [7:0] d);
		exp_q.push_back({err, 24'h0, d});
		apb(idx, 1'b0, rnd());
	endtask

	// Read results are matched against the oldest note
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1 && !pwrite)
			if (exp_q.size() == 0) begin
				errors++;
				$display("[ERR] %0t read with nothing expected", $time);
			end else
				check({pslverr, prdata}, exp_q.pop_front());

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		ck(ser_pull_up_en, 8'hFF);
		ck(ad_pad.oe | ad_pad.pull_en, 8'h00);
		ck(tm_pad.oe | tm_pad.pull_en, 8'h00);
		ck({7'h0, edge_irq_req}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			rd(8'(IDX_AD_DIR + i), 1'b0, 8'h00);
		end
		rd(8'h50, 1'b1, 8'h00);
		$display("reset and map test done");
		for (int k = 0; k < 6; k++) begin
			r = rnd();
			ad_ext <= r[7:0];
			ad_conv_en <= r[15:8];
			ad_periph <= {r[23:16] & r[31:24], r[31:24], r[7:0] ^ 8'h5A};
			dir = 8'(rnd());
			dat = 8'(rnd());
			rdr = 8'(rnd());
			pe = 8'(rnd());
			ps = 8'(rnd());
			wr(IDX_AD_DATA, dat);
			wr(IDX_AD_DIR, dir);
			wr(IDX_AD_RDR, rdr);
			wr(IDX_AD_PE, pe);
			wr(IDX_AD_PS, ps);
			wr(IDX_AD_IN, 8'(rnd()));
			repeat (3) @(posedge pclk);
			@(negedge pclk);
			oe = (ad_periph.own & ad_periph.oe) | (~ad_periph.own & dir);
			out = (ad_periph.own & ad_periph.out) | (~ad_periph.own & dat);
			pe_eff = pe & ~oe & ~ad_conv_en;
			pin = (oe & out) | (~oe & pe_eff & ~ps) | (~oe & ~pe_eff & ad_ext);
			ck(ad_pad.oe, oe);
			ck(ad_pad.out & oe, out & oe);
			ck(ad_drive_reduced, rdr & oe);
			ck(ad_pad.pull_en, pe_eff);
			ck(ad_pad.pull_up & pe_eff, ~ps & pe_eff);
			rd(IDX_AD_DATA, 1'b0, (dir & dat) | (~dir & pin));
			rd(IDX_AD_IN, 1'b0, pin);
		end
		// Converter read set-up: direction cleared, channels enabled
		dat = 8'(rnd());
		ad_ext <= dat;
		ad_periph <= '0;
		ad_conv_en <= 8'hFF;
		wr(IDX_AD_DIR, 8'h00);
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		ck(ad_pad.oe | ad_pad.pull_en, 8'h00);
		rd(IDX_AD_IN, 1'b0, dat);
		for (int k = 0; k < 3; k++) begin
			@(posedge pclk);
			ser_periph_oe <= 8'(rnd());
			pe = 8'(rnd());
			ps = 8'(rnd());
			wr(IDX_SER_PE, pe);
			wr(IDX_SER_WOR, ps);
			@(negedge pclk);
			ck(ser_pull_up_en, pe & (~ser_periph_oe | ps));
		end
		@(posedge pclk);
		pwm_out <= 8'(rnd());
		wr(IDX_REROUTE, 8'hFF);
		wr(IDX_TM_DIR, 8'h00);
		@(negedge pclk);
		ck(tm_pad.oe & tm_pad.out, pwm_out);
		dat = 8'(rnd());
		wr(IDX_REROUTE, 8'h00);
		wr(IDX_TM_DIR, 8'hFF);
		wr(IDX_TM_DATA, dat);
		@(negedge pclk);
		ck(tm_pad.out, dat);
		ck(tm_pad.pull_en, 8'h00);
		@(posedge pclk);
		tm_periph <= {8'h0F, 8'h05, 8'h03};
		@(negedge pclk);
		ck(tm_pad.oe, 8'hF5);
		ck(tm_pad.out, 8'h03 | (dat & 8'hF0));
		$display("pin config test done");
		wr(IDX_EP_DIR, 8'h00);
		wr(IDX_EP_PE, 8'h00);
		wr(IDX_EP_IE, 8'hFF);
		@(negedge pclk);
		ck(ep_pad.oe | ep_pad.pull_en, 8'h00);
		for (int p = 0; p < 2; p++) begin
			idle = p ? 8'h00 : 8'hFF;
			wr(IDX_EP_POL, ~idle);
			ep_ext <= idle;
			repeat (8) @(posedge pclk);
			wr(IDX_EP_IF, 8'hFF);
			@(negedge pclk);
			ck(ep_pad.pull_up, idle);
			@(posedge pclk);
			ep_ext <= ~idle;
			repeat (3) @(posedge pclk);
			ep_ext <= idle;
			repeat (12) @(posedge pclk);
			rd(IDX_EP_IF, 1'b0, 8'h00);
			ep_ext <= ~idle;
			repeat (4) @(posedge pclk);
			ep_ext <= idle;
			repeat (12) @(posedge pclk);
			rd(IDX_EP_IF, 1'b0, 8'hFF);
			stop_mode <= 1'b1;
			@(negedge pclk);
			ck({6'h0, edge_irq_req, wakeup_req}, 8'h03);
			ck({7'h0, rc_osc_run}, 8'h00);
			wr(IDX_EP_IE, 8'h0F);
			wr(IDX_EP_IF, 8'h00);
			rd(IDX_EP_IF, 1'b0, 8'hFF);
			wr(IDX_EP_IF, 8'h0F);
			rd(IDX_EP_IF, 1'b0, 8'hF0);
			@(negedge pclk);
			ck({6'h0, edge_irq_req, rc_osc_run}, 8'h01);
			@(posedge pclk);
			stop_mode <= 1'b0;
			wr(IDX_EP_IE, 8'hFF);
		end
		wr(IDX_EP_DATA, 8'hA5);
		wr(IDX_EP_DIR, 8'h0F);
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		ck(ep_pad.oe, 8'h0F);
		ck(ep_pad.out, 8'hA5);
		rd(IDX_EP_DATA, 1'b0, 8'h05);
		$display("edge interrupt test done");
		repeat (4) @(posedge pclk);
		stop_test();
	end
endmodule
